// >>> rtl/rtc_periodic_interrupt_timer.sv
// periodic interrupt timer of the real-time counter, with the match value register
//
// Functional notes
// - sixteen-bit match value, two bytes, reset zero
// - period code selects power-of-two interval, 0x0 off
// - enable bit one starts, zero stops
// - busy while control settings cross over
// - interrupt enable bit zero of enable register
// - flag sets whenever selected period elapses
// - writing one clears flag, zero keeps
// - halted without debug-run: stop, ignore events
// - debug-run set: keep running while halted
// - two-bit select chooses counter clock source
// - low byte at base, high one above
// - shared temp byte makes 16-bit access atomic
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "pit_map.svh"

module rtc_periodic_interrupt_timer #(
   parameter int PRESCALE_W = 15
) (
   input wire logic MCLK_I,
   input wire logic RESET_N_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic OSC_32K_I,
   input wire logic OSC_1K_I,
   input wire logic XOSC_I,
   input wire logic EXT_CLK_I,
   input wire logic DEBUG_HALT_I,
   output logic IRQ_O
);

   // the longest period needs 15 bits of prescaler
   generate
      if (PRESCALE_W != 15) begin : g_width_check
         $error("PRESCALE_W must be 15");
      end
   endgenerate

   pit_pkg::pit_state_t st;
   pit_pkg::pit_state_t next_st;
   logic rtc_tick;
   logic count_tick;
   logic period_valid;
   logic [14:0] period_limit;
   logic wr_ctrl;
   logic wr_flag;
   logic rd_flag;
   logic period_done;

   // edge finder on the selected counter clock
   pit_clock_edge u_edge (
      .clk(MCLK_I),
      .reset_n(RESET_N_I),
      .source_select_i(st.counter_clock_source),
      .internal_32k_i(OSC_32K_I),
      .internal_1k_i(OSC_1K_I),
      .crystal_i(XOSC_I),
      .external_pin_i(EXT_CLK_I),
      .tick_o(rtc_tick)
   );

   // the sync counter must be able to finish a transfer
   generate
      if (`SYNC_TICKS == 2'h0) begin : g_sync_check
         $error("transfer needs at least one counter tick");
      end
   endgenerate

   // last prescaler count of a period: 2^(code+1) - 1
   // a code change while counting keeps the prescaler; the compare uses the new limit
   function automatic logic [14:0] limit_of(input logic [3:0] code);
      logic [15:0] span;
      span = 16'h0002 << code;
      limit_of = span[14:0] - 15'h0001;
   endfunction : limit_of

   // one-hot register select; an unmapped address selects nothing and reads zero
   logic hit_temp;
   logic hit_source;
   logic hit_match_low;
   logic hit_match_high;
   logic hit_control;
   logic hit_status;
   logic hit_irq_enable;
   logic hit_flag;
   logic hit_debug;

   always_comb begin
      hit_temp = 1'b0;
      hit_source = 1'b0;
      hit_match_low = 1'b0;
      hit_match_high = 1'b0;
      hit_control = 1'b0;
      hit_status = 1'b0;
      hit_irq_enable = 1'b0;
      hit_flag = 1'b0;
      hit_debug = 1'b0;
      if (ADDR_I == `OFS_TEMP_BYTE) begin
         hit_temp = 1'b1;
      end else if (ADDR_I == `OFS_CLOCK_SOURCE) begin
         hit_source = 1'b1;
      end else if (ADDR_I == `OFS_MATCH_LOW) begin
         hit_match_low = 1'b1;
      end else if (ADDR_I == `OFS_MATCH_HIGH) begin
         hit_match_high = 1'b1;
      end else if (ADDR_I == `OFS_PIT_CONTROL) begin
         hit_control = 1'b1;
      end else if (ADDR_I == `OFS_PIT_SYNC_STATUS) begin
         hit_status = 1'b1;
      end else if (ADDR_I == `OFS_PIT_IRQ_ENABLE) begin
         hit_irq_enable = 1'b1;
      end else if (ADDR_I == `OFS_PIT_IRQ_FLAG) begin
         hit_flag = 1'b1;
      end else if (ADDR_I == `OFS_PIT_DEBUG_CONTROL) begin
         hit_debug = 1'b1;
      end
   end

   // write and read strobes per register
   logic wr_temp;
   logic wr_source;
   logic wr_match_low;
   logic wr_match_high;
   logic wr_irq_enable;
   logic wr_debug;
   logic rd_match_low;

   assign wr_temp = WR_I && hit_temp;
   assign wr_source = WR_I && hit_source;
   assign wr_match_low = WR_I && hit_match_low;
   assign wr_match_high = WR_I && hit_match_high;
   assign wr_ctrl = WR_I && hit_control;
   assign wr_irq_enable = WR_I && hit_irq_enable;
   assign wr_flag = WR_I && hit_flag;
   assign wr_debug = WR_I && hit_debug;
   assign rd_match_low = RD_I && hit_match_low;
   assign rd_flag = RD_I && hit_flag;

   // readable images of the registers, reserved bits held at zero
   logic [7:0] source_view;
   logic [7:0] control_view;
   logic [7:0] status_view;
   logic [7:0] irq_enable_view;
   logic [7:0] flag_view;
   logic [7:0] debug_view;

   always_comb begin
      // clock source select in the low bits
      source_view = `RST_BYTE;
      source_view[`POS_CLOCK_SOURCE_MSB:0] = st.counter_clock_source;

      // period field and enable bit as written, not as yet active
      control_view = `RST_BYTE;
      control_view[`POS_PERIOD_MSB:`POS_PERIOD_LSB] = st.period;
      control_view[`POS_TIMER_ENABLE] = st.periodic_timer_enable;

      // transfer still pending
      status_view = `RST_BYTE;
      status_view[`POS_TRANSFER_PENDING] = st.settings_transfer_pending;

      // interrupt enable
      irq_enable_view = `RST_BYTE;
      irq_enable_view[`POS_PERIODIC_IRQ] = st.periodic_irq_enable;

      // sticky flag
      flag_view = `RST_BYTE;
      flag_view[`POS_PERIODIC_IRQ] = st.periodic_interrupt;

      // debug-run bit
      debug_view = `RST_BYTE;
      debug_view[`POS_RUN_WHILE_HALTED] = st.run_while_halted;
   end

   // read multiplexer; unmapped addresses fall through to zero
   logic [7:0] read_mux;

   always_comb begin
      if (hit_temp) begin
         read_mux = st.temp_byte;
      end else if (hit_source) begin
         read_mux = source_view;
      end else if (hit_match_low) begin
         read_mux = st.match_value[7:0];
      end else if (hit_match_high) begin
         // high byte comes from temp, filled by the low byte read
         read_mux = st.temp_byte;
      end else if (hit_control) begin
         read_mux = control_view;
      end else if (hit_status) begin
         read_mux = status_view;
      end else if (hit_irq_enable) begin
         read_mux = irq_enable_view;
      end else if (hit_flag) begin
         read_mux = flag_view;
      end else if (hit_debug) begin
         read_mux = debug_view;
      end else begin
         read_mux = `RST_BYTE;
      end
   end

   // period codes 0x1..0xE count, off and reserved do not
   assign period_valid = (st.active_period != `PERIOD_CODE_OFF) &&
                         (st.active_period != `PERIOD_CODE_RESERVED);
   assign period_limit = limit_of(st.active_period);

   // counting helpers
   logic ticks_blocked;
   logic timer_running;
   logic period_hit;
   logic transfer_done;
   logic flag_clear;

   // while halted, ticks are dropped unless debug-run is set
   assign ticks_blocked = DEBUG_HALT_I & ~st.run_while_halted;
   assign count_tick = rtc_tick & ~ticks_blocked;

   // stopped or with an off or reserved code, the prescaler is parked at zero
   assign timer_running = st.active_enable && period_valid;

   // last count of the active period reached
   assign period_hit = (st.prescaler == period_limit);
   assign period_done = count_tick && timer_running && period_hit;

   // the second counter tick of a pending transfer hands the settings over;
   // ticks are taken even while halted so software is never left waiting
   assign transfer_done = st.settings_transfer_pending && rtc_tick &&
                          (st.sync_count == (`SYNC_TICKS - 2'h1));

   // write-one or any read of the flag register clears it
   assign flag_clear = (wr_flag && WDATA_I[`POS_PERIODIC_IRQ]) || rd_flag;

   // next state of the whole block
   always_comb begin
      next_st = st;
      next_st.rdata = `RST_BYTE;

      // the low match byte parks in temp until the high byte completes the word
      if (wr_temp || wr_match_low) begin
         next_st.temp_byte = WDATA_I;
      end

      // clock source
      if (wr_source) begin
         next_st.counter_clock_source = WDATA_I[`POS_CLOCK_SOURCE_MSB:0];
      end

      // high byte commits the whole word at once
      if (wr_match_high) begin
         next_st.match_value = {WDATA_I, st.temp_byte};
      end

      // control settings wait here until the transfer completes
      if (wr_ctrl) begin
         next_st.period = WDATA_I[`POS_PERIOD_MSB:`POS_PERIOD_LSB];
         next_st.periodic_timer_enable = WDATA_I[`POS_TIMER_ENABLE];
      end

      // interrupt enable and debug-run take effect at once
      if (wr_irq_enable) begin
         next_st.periodic_irq_enable = WDATA_I[`POS_PERIODIC_IRQ];
      end
      if (wr_debug) begin
         next_st.run_while_halted = WDATA_I[`POS_RUN_WHILE_HALTED];
      end

      // read data stand in the next cycle only
      if (RD_I) begin
         next_st.rdata = read_mux;
      end
      // reading the low byte copies the high byte so the pair stays coherent
      if (rd_match_low) begin
         next_st.temp_byte = st.match_value[15:8];
      end

      // carry control settings into the counting logic after two counter ticks;
      // a new write restarts the transfer so the last value always wins
      if (wr_ctrl) begin
         next_st.settings_transfer_pending = 1'b1;
         next_st.sync_count = 2'h0;
      end else if (transfer_done) begin
         next_st.settings_transfer_pending = 1'b0;
         next_st.sync_count = 2'h0;
         next_st.active_period = st.period;
         next_st.active_enable = st.periodic_timer_enable;
      end else if (st.settings_transfer_pending && rtc_tick) begin
         next_st.sync_count = st.sync_count + 2'h1;
      end

      // prescaler: cleared while stopped, holds while halted without debug-run
      if (!timer_running || period_done) begin
         next_st.prescaler = 15'h0000;
      end else if (count_tick) begin
         next_st.prescaler = st.prescaler + 15'h0001;
      end

      // flag: a new period in the same cycle as a clear wins
      if (period_done) begin
         next_st.periodic_interrupt = 1'b1;
      end else if (flag_clear) begin
         next_st.periodic_interrupt = 1'b0;
      end

      // level request from the next flag and enable, registered with them
      next_st.irq = next_st.periodic_interrupt & next_st.periodic_irq_enable;
   end

   // the single state register
   always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st.match_value <= `RST_MATCH;
         st.temp_byte <= `RST_BYTE;
         st.counter_clock_source <= `RST_CLOCK_SOURCE;
         st.period <= `RST_PERIOD;
         st.periodic_timer_enable <= 1'b0;
         st.active_period <= `RST_PERIOD;
         st.active_enable <= 1'b0;
         st.settings_transfer_pending <= 1'b0;
         st.sync_count <= 2'h0;
         st.periodic_irq_enable <= 1'b0;
         st.periodic_interrupt <= 1'b0;
         st.run_while_halted <= 1'b0;
         st.prescaler <= 15'h0000;
         st.rdata <= `RST_BYTE;
         st.irq <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign RDATA_O = st.rdata;
   assign IRQ_O = st.irq;

endmodule : rtc_periodic_interrupt_timer

// >>> shared/pit_map.svh
// register offsets, field positions, reset values and counts of the periodic interrupt timer
`ifndef PIT_MAP_SVH
`define PIT_MAP_SVH

// byte offsets on the register port
`define OFS_TEMP_BYTE 8'h04
`define OFS_CLOCK_SOURCE 8'h07
`define OFS_MATCH_LOW 8'h0C
`define OFS_MATCH_HIGH 8'h0D
`define OFS_PIT_CONTROL 8'h10
`define OFS_PIT_SYNC_STATUS 8'h11
`define OFS_PIT_IRQ_ENABLE 8'h12
`define OFS_PIT_IRQ_FLAG 8'h13
`define OFS_PIT_DEBUG_CONTROL 8'h15

// field positions
`define POS_TIMER_ENABLE 0
`define POS_PERIOD_LSB 3
`define POS_PERIOD_MSB 6
`define POS_TRANSFER_PENDING 0
`define POS_PERIODIC_IRQ 0
`define POS_RUN_WHILE_HALTED 0
`define POS_CLOCK_SOURCE_MSB 1

// reset values
`define RST_BYTE 8'h00
`define RST_MATCH 16'h0000
`define RST_PERIOD 4'h0
`define RST_CLOCK_SOURCE 2'h0

// period codes
`define PERIOD_CODE_OFF 4'h0
`define PERIOD_CODE_RESERVED 4'hF

// counter clock edges needed to carry control settings across
`define SYNC_TICKS 2'h2

// counter clock source codes
`define SRC_INTERNAL_32K 2'h0
`define SRC_INTERNAL_1K 2'h1
`define SRC_CRYSTAL 2'h2
`define SRC_EXTERNAL_PIN 2'h3

`endif

// >>> shared/pit_pkg.sv
// state types of the periodic interrupt timer
package pit_pkg;

   // state of the counter clock edge finder
   typedef struct packed {
      logic level;
   } edge_state_t;

   // whole state of the timer block
   typedef struct packed {
      logic [15:0] match_value;
      logic [7:0] temp_byte;
      logic [1:0] counter_clock_source;
      logic [3:0] period;
      logic periodic_timer_enable;
      logic [3:0] active_period;
      logic active_enable;
      logic settings_transfer_pending;
      logic [1:0] sync_count;
      logic periodic_irq_enable;
      logic periodic_interrupt;
      logic run_while_halted;
      logic [14:0] prescaler;
      logic [7:0] rdata;
      logic irq;
   } pit_state_t;

endpackage : pit_pkg

// >>> rtl/pit_clock_edge.sv
// selects the counter clock source and turns its rising edges into one-cycle ticks
`timescale 1ns/1ps
`include "pit_map.svh"

module pit_clock_edge (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] source_select_i,
   input wire logic internal_32k_i,
   input wire logic internal_1k_i,
   input wire logic crystal_i,
   input wire logic external_pin_i,
   output logic tick_o
);

   pit_pkg::edge_state_t st;
   pit_pkg::edge_state_t next_st;
   logic chosen;

   // source mux
   always_comb begin
      if (source_select_i == `SRC_INTERNAL_32K) begin
         chosen = internal_32k_i;
      end else if (source_select_i == `SRC_INTERNAL_1K) begin
         chosen = internal_1k_i;
      end else if (source_select_i == `SRC_CRYSTAL) begin
         chosen = crystal_i;
      end else begin
         chosen = external_pin_i;
      end
      next_st = st;
      next_st.level = chosen;
   end

   // a source switch may give one spurious tick; software reprograms while stopped
   assign tick_o = chosen & ~st.level;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : pit_clock_edge

// >>> sim/pit_checker.sv
// port-level assertions of the periodic interrupt timer
`timescale 1ns/1ps

module pit_checker #(
   parameter int PRESCALE_W = 15
) (
   input wire logic MCLK_I,
   input wire logic RESET_N_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [7:0] RDATA_O,
   input wire logic OSC_32K_I,
   input wire logic OSC_1K_I,
   input wire logic XOSC_I,
   input wire logic EXT_CLK_I,
   input wire logic DEBUG_HALT_I,
   input wire logic IRQ_O
);
   // all sources still means no period can end, so a clear must win
   wire [3:0] src = {EXT_CLK_I, XOSC_I, OSC_1K_I, OSC_32K_I};

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RESET_N_I);

   rd_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
      else $error("read data not idle");
   status_res_a: assert property (RD_I && ADDR_I == 8'h11 |=> RDATA_O[7:1] == 7'h00)
      else $error("status reserved bits set");
   ctrl_res_a: assert property (RD_I && ADDR_I == 8'h10
      |=> {RDATA_O[7], RDATA_O[2:1]} == 3'h0) else $error("control reserved bits set");
   flag_res_a: assert property (RD_I && ADDR_I == 8'h13 |=> RDATA_O[7:1] == 7'h00)
      else $error("flag reserved bits set");
   busy_set_a: assert property (WR_I && ADDR_I == 8'h10 ##1 RD_I && ADDR_I == 8'h11
      |=> RDATA_O[0]) else $error("busy not shown after control write");
   mask_off_a: assert property (WR_I && ADDR_I == 8'h12 && !WDATA_I[0] |=> !IRQ_O)
      else $error("masked interrupt still high");
   flag_clear_a: assert property (WR_I && ADDR_I == 8'h13 && WDATA_I[0]
      && $stable(src) && src == $past(src, 2) |=> !IRQ_O) else $error("flag not cleared");
   match_rb_a: assert property (WR_I && ADDR_I == 8'h0C ##1 WR_I && ADDR_I == 8'h0D
      ##1 RD_I && ADDR_I == 8'h0C |=> RDATA_O == $past(WDATA_I, 3))
      else $error("match low byte lost");
endmodule : pit_checker

bind rtc_periodic_interrupt_timer pit_checker #(.PRESCALE_W(PRESCALE_W)) chk_u (
   .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
   .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .OSC_32K_I(OSC_32K_I), .OSC_1K_I(OSC_1K_I),
   .XOSC_I(XOSC_I), .EXT_CLK_I(EXT_CLK_I), .DEBUG_HALT_I(DEBUG_HALT_I), .IRQ_O(IRQ_O)
);

// >>> sim/tb_top.sv
// self-checking bench of the periodic interrupt timer
`timescale 1ns/1ps

module tb_top;
   logic mclk = 1'b0, rst_n = 1'b0, wen = 1'b0, ren = 1'b0, halt = 1'b0, irq;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [3:0] osc = 4'h0;
   int error_cnt = 0, checks_done = 0, sel = 0;

   rtc_periodic_interrupt_timer #(.PRESCALE_W(15)) dut_u (
      .MCLK_I(mclk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wen),
      .RD_I(ren), .RDATA_O(rdata), .OSC_32K_I(osc[0]), .OSC_1K_I(osc[1]), .XOSC_I(osc[2]),
      .EXT_CLK_I(osc[3]), .DEBUG_HALT_I(halt), .IRQ_O(irq)
   );

   // 10 MHz system clock
   initial forever #50 mclk = ~mclk;

   task automatic final_report();
      if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp

   // the write strobe stays up until the next task takes over, so writes run back to back; a read drops its strobe after one cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wen <= 1'b1;
      ren <= 1'b0;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      wen <= 1'b0;
      ren <= 1'b1;
      addr <= a;
      @(posedge mclk);
      ren <= 1'b0;
      @(negedge mclk);
      cmp(rdata, e);
      @(posedge mclk);
   endtask : rd

   // source edges six system cycles apart, well below half the system rate
   task automatic tk(input int n);
      wen <= 1'b0;
      repeat (n) begin
         osc[sel] <= 1'b1;
         repeat (3) @(posedge mclk);
         osc[sel] <= 1'b0;
         repeat (3) @(posedge mclk);
      end
   endtask : tk

   task automatic ck(input logic e);
      wen <= 1'b0;
      @(posedge mclk);
      @(negedge mclk);
      cmp({7'h00, irq}, {7'h00, e});
      @(posedge mclk);
   endtask : ck

   task automatic t_reset();
      for (int a = 0; a < 32; a++) rd(8'(a), 8'h00);
   endtask : t_reset

   task automatic t_match();
      wr(8'h0C, 8'hA5);
      wr(8'h0D, 8'h3C);
      rd(8'h0C, 8'hA5);
      rd(8'h0D, 8'h3C);
      wr(8'h04, 8'h77);
      wr(8'h0D, 8'h11);
      rd(8'h0C, 8'h77);
      rd(8'h0D, 8'h11);
      wr(8'h07, 8'hFF);
      rd(8'h07, 8'h03);
   endtask : t_match

   // every source with its own period, counted to the exact tick
   task automatic t_periods();
      wr(8'h12, 8'hFF);
      rd(8'h12, 8'h01);
      for (int i = 0; i < 4; i++) begin
         sel = i;
         wr(8'h07, 8'(i));
         wr(8'h13, 8'h01);
         wr(8'h10, 8'((i + 1) * 8 + 1));
         rd(8'h11, 8'h01);
         tk(2);
         rd(8'h11, 8'h00);
         tk((4 << i) - 1);
         ck(1'b0);
         tk(1);
         ck(1'b1);
         wr(8'h10, 8'h00);
         tk(2);
         wr(8'h13, 8'h01);
      end
   endtask : t_periods

   task automatic t_flags();
      sel = 0;
      wr(8'h07, 8'h00);
      wr(8'h10, 8'h09);
      tk(6);
      ck(1'b1);
      wr(8'h13, 8'h00);
      ck(1'b1);
      wr(8'h12, 8'h00);
      ck(1'b0);
      wr(8'h12, 8'h01);
      ck(1'b1);
      wr(8'h13, 8'h01);
      ck(1'b0);
   endtask : t_flags

   // halted counting, then reserved and disabled settings
   task automatic t_halt();
      halt <= 1'b1;
      tk(8);
      ck(1'b0);
      wr(8'h15, 8'hFF);
      rd(8'h15, 8'h01);
      tk(4);
      ck(1'b1);
      halt <= 1'b0;
      rd(8'h13, 8'h01);
      ck(1'b0);
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h79);
      tk(10);
      ck(1'b0);
      wr(8'h10, 8'h08);
      tk(10);
      ck(1'b0);
      wr(8'h10, 8'h01);
      tk(10);
      ck(1'b0);
   endtask : t_halt

   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_match();
      t_periods();
      t_flags();
      t_halt();
      final_report();
   end

   // the whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      final_report();
   end
endmodule : tb_top
